// ### core/sdpp_pkg.sv
// Purpose: shared constants and types of the divider programming port
// Assumes: apb register map with 32-bit words, byte addresses
// Notes:   frame layout is fixed here and used by both shift and load logic

package sdpp_pkg;

  // ----------------------------------------------------------------
  // serial frame, first bit shifted in ends at the top
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        diag_select_hi;          // diagnostic select, high bit
    logic        diag_select_lo;          // diagnostic select, low bit
    logic [2:0]  out_divide_b_select;     // output divider b code
    logic [2:0]  out_divide_a_select;     // output divider a code
    logic [2:0]  pre_divide_select;       // reference pre-divider code
    logic [5:0]  feedback_whole_field;    // feedback integer part
    logic [11:0] feedback_fraction_field; // feedback part in 1/4096
  } sdpp_frame_t;

  // parallel divider pins
  typedef struct packed {
    logic [2:0]  pre_divide_select;       // pre-divider select pins
    logic [5:0]  feedback_whole_field;    // feedback integer pins
    logic [2:0]  out_divide_a_select;     // output a select pins
    logic [2:0]  out_divide_b_select;     // output b select pins
  } sdpp_pins_t;

  localparam int unsigned SDPP_FRAME_BITS = 29;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned SDPP_ADDR_W      = 12;
  localparam logic [11:0] SDPP_OFS_CTRL    = 12'h000;
  localparam logic [11:0] SDPP_OFS_FEEDBK  = 12'h004;
  localparam logic [11:0] SDPP_OFS_DIVSEL  = 12'h008;

  localparam int unsigned SDPP_CTRL_REF_SEL_BIT = 0;
  localparam int unsigned SDPP_CTRL_REF_OE_BIT  = 1;
  localparam int unsigned SDPP_FB_FRAC_LSB      = 0;
  localparam int unsigned SDPP_FB_WHOLE_LSB     = 16;
  localparam int unsigned SDPP_DS_PRE_LSB       = 0;
  localparam int unsigned SDPP_DS_NA_LSB        = 4;
  localparam int unsigned SDPP_DS_NB_LSB        = 8;
  localparam int unsigned SDPP_DS_DIAG_LSB      = 12;
  localparam int unsigned SDPP_DS_SERIAL_BIT    = 16;
  localparam int unsigned SDPP_DS_RATIO_LSB     = 24;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  SDPP_CTRL_RESET  = 2'h0;
  localparam logic [1:0]  SDPP_DIAG_SR_OUT = 2'h1;
  localparam logic [1:0]  SDPP_BOOT_CYCLES = 2'h3;
  localparam logic [5:0]  SDPP_RATIO_RESET = 6'h01;

  // pre-divider code to ratio 1,2,4,5,8,16,25,32
  function automatic logic [5:0] sdpp_pre_ratio(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h01;
    case (code)
      3'h0: r = 6'h01;
      3'h1: r = 6'h02;
      3'h2: r = 6'h04;
      3'h3: r = 6'h05;
      3'h4: r = 6'h08;
      3'h5: r = 6'h10;
      3'h6: r = 6'h19;
      default: r = 6'h20;
    endcase
    return r;
  endfunction

endpackage

// ### core/sdpp_top.sv
// Purpose: programming port of a fractional-n synthesizer
// Assumes: pclk 50 MHz, shift_clk runs only while a frame is shifted
// Notes:   parallel pins and strobes are synchronised into pclk
//
// The APB interface to the registers and the register addresses were decided locally.

`timescale 1ns/10ps

// Functional notes
// - feedback divider: 6-bit whole, 12-bit fraction
// - pre-divider ratio from pins or serial
// - two-way reference source selector
// - two independent output divider selects
// - reference copy output disabled after reset
// - parallel load never touches the fraction
// - strobe low: divider pins pass straight through
// - strobe rise holds settings until low/serial
// - strapped pins give power-up default settings
// - diagnostic output low in parallel mode
// - serial mode: strobe high, load strobe low
// - shift data in on shift clock rise
// - load strobe rise transfers shift register
// - load strobe fall holds transferred settings
// - frame carries dividers and diagnostic selects
// - diag code 00 low, 01 shift output
module sdpp_top (
  input  wire logic                pclk,                       // bus clock
  input  wire logic                presetn,                    // async reset, low
  input  wire logic                psel,                       // apb select
  input  wire logic                penable,                    // apb enable
  input  wire logic                pwrite,                     // apb direction
  input  wire logic [11:0]         paddr,                      // apb byte address
  input  wire logic [31:0]         pwdata,                     // apb write data
  output logic      [31:0]         prdata,                     // apb read data
  output logic                     pready,                     // apb ready
  output logic                     pslverr,                    // apb error
  input  wire logic                shift_clk,                  // serial shift clock
  input  wire logic                serial_data_in,             // serial data pin
  input  wire logic                serial_load_strobe,         // serial load pin
  input  wire logic                parallel_latch_strobe_n,    // parallel latch pin
  input  wire sdpp_pkg::sdpp_pins_t par_pins,                  // divider pins
  output sdpp_pkg::sdpp_frame_t    divider_settings,           // active settings
  output logic      [5:0]          pre_divide_ratio,           // decoded ratio
  output logic                     ref_select,                 // 1 diff in, 0 xtal
  output logic                     ref_out_enable,             // reference copy on
  output logic                     serial_mode,                // serial mode level
  output logic                     diag_out                    // diagnostic pin
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SDPP_BOOT   = 4'b0001,                // sampling straps
    SDPP_FOLLOW = 4'b0010,                // pins pass through
    SDPP_HOLD   = 4'b0100,                // settings held
    SDPP_SLOAD  = 4'b1000                 // serial transfer
  } sdpp_state_t;

  sdpp_state_t              state_reg;    // mode state
  sdpp_state_t              state_next;   // next mode state
  localparam int unsigned SDPP_FRAME_W = sdpp_pkg::SDPP_FRAME_BITS;
  logic [SDPP_FRAME_W-1:0]  shift_reg;    // serial shift register
  sdpp_pkg::sdpp_pins_t     pins_s1_reg;  // pin sync stage 1
  sdpp_pkg::sdpp_pins_t     pins_s2_reg;  // pin sync stage 2
  logic                     psn_s1_reg;   // strobe sync stage 1
  logic                     psn_s2_reg;   // strobe sync stage 2
  logic                     sl_s1_reg;    // load sync stage 1
  logic                     sl_s2_reg;    // load sync stage 2
  logic                     sl_d_reg;     // load, one later
  logic                     msb_s1_reg;   // shift msb sync 1
  logic                     msb_s2_reg;   // shift msb sync 2
  logic [1:0]               boot_reg;     // boot countdown
  sdpp_pkg::sdpp_frame_t    active_reg;   // active settings
  sdpp_pkg::sdpp_frame_t    frame_w;      // shift reg as frame
  logic [5:0]               ratio_reg;    // decoded pre ratio
  logic [1:0]               ctrl_reg;     // control bits
  logic                     diag_reg;     // diagnostic output
  logic                     smode_reg;    // serial mode flag
  logic [31:0]              prdata_reg;   // read data
  logic                     sl_rise;      // load strobe rising
  logic                     setup_ph;     // apb setup phase
  logic                     access_ph;    // apb access phase
  logic                     mapped;       // address decodes
  logic [31:0]              rd_mux;       // read value

  // ----------------------------------------------------------------
  // serial shift register, shift clock domain
  // ----------------------------------------------------------------

  // shifts on every rising edge; the mode gate sits at the transfer,
  // since the strobes cannot be synchronised on a gated clock
  always_ff @(posedge shift_clk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= {shift_reg[SDPP_FRAME_W-2:0], serial_data_in};
    end
  end

  // frame view of the shift register
  assign frame_w = sdpp_pkg::sdpp_frame_t'(shift_reg);

  // ----------------------------------------------------------------
  // synchronisers into pclk
  // ----------------------------------------------------------------

  // two flops on every pin that the control logic reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      psn_s1_reg  <= 1'b0;
      psn_s2_reg  <= 1'b0;
      sl_s1_reg   <= 1'b0;
      sl_s2_reg   <= 1'b0;
      msb_s1_reg  <= 1'b0;
      msb_s2_reg  <= 1'b0;
    end else begin
      pins_s1_reg <= par_pins;
      pins_s2_reg <= pins_s1_reg;
      psn_s1_reg  <= parallel_latch_strobe_n;
      psn_s2_reg  <= psn_s1_reg;
      sl_s1_reg   <= serial_load_strobe;
      sl_s2_reg   <= sl_s1_reg;
      msb_s1_reg  <= shift_reg[SDPP_FRAME_W-1];
      msb_s2_reg  <= msb_s1_reg;
    end
  end

  // delayed copy for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl_d_reg <= 1'b0;
    end else begin
      sl_d_reg <= sl_s2_reg;
    end
  end

  assign sl_rise = sl_s2_reg & ~sl_d_reg;

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------

  // boot waits until the pin synchronisers are filled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= sdpp_pkg::SDPP_BOOT_CYCLES;
    end else if (state_reg == SDPP_BOOT) begin
      boot_reg <= boot_reg - 2'h1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SDPP_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  // transitions; strobe low always wins back to pass-through
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SDPP_BOOT: begin
        if (boot_reg == 2'h0) begin
          state_next = psn_s2_reg ? SDPP_HOLD : SDPP_FOLLOW;
        end
      end
      SDPP_FOLLOW: begin
        if (psn_s2_reg) begin
          state_next = SDPP_HOLD;
        end
      end
      SDPP_HOLD: begin
        if (!psn_s2_reg) begin
          state_next = SDPP_FOLLOW;
        end else if (sl_rise) begin
          state_next = SDPP_SLOAD;
        end
      end
      SDPP_SLOAD: begin
        if (!psn_s2_reg) begin
          state_next = SDPP_FOLLOW;
        end else if (!sl_s2_reg) begin
          state_next = SDPP_HOLD;
        end
      end
      default: begin
        state_next = SDPP_BOOT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // active divider settings
  // ----------------------------------------------------------------

  // the shift register stands still while the load strobe is
  // high, so it is read here only in that window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= '0;
    end else begin
      case (state_reg)
        SDPP_BOOT, SDPP_FOLLOW: begin
          // fraction and diag selects are kept as they are
          active_reg.pre_divide_select    <= pins_s2_reg.pre_divide_select;
          active_reg.feedback_whole_field <= pins_s2_reg.feedback_whole_field;
          active_reg.out_divide_a_select  <= pins_s2_reg.out_divide_a_select;
          active_reg.out_divide_b_select  <= pins_s2_reg.out_divide_b_select;
        end
        SDPP_SLOAD: begin
          active_reg <= frame_w;
        end
        default: begin
          active_reg <= active_reg;
        end
      endcase
    end
  end

  // decoded pre-divider ratio
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_reg <= sdpp_pkg::SDPP_RATIO_RESET;
    end else begin
      ratio_reg <= sdpp_pkg::sdpp_pre_ratio(active_reg.pre_divide_select);
    end
  end

  // ----------------------------------------------------------------
  // diagnostic output
  // ----------------------------------------------------------------

  // serial mode needs both strobe levels, checked after sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smode_reg <= 1'b0;
    end else begin
      smode_reg <= (state_reg != SDPP_BOOT) & psn_s2_reg & ~sl_s2_reg;
    end
  end

  // only code 01 drives the pin; reserved codes read low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_reg <= 1'b0;
    end else if (!smode_reg) begin
      diag_reg <= 1'b0;
    end else if ({active_reg.diag_select_hi, active_reg.diag_select_lo} == sdpp_pkg::SDPP_DIAG_SR_OUT) begin
      diag_reg <= msb_s2_reg;
    end else begin
      diag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign mapped    = (paddr == sdpp_pkg::SDPP_OFS_CTRL)
                   | (paddr == sdpp_pkg::SDPP_OFS_FEEDBK)
                   | (paddr == sdpp_pkg::SDPP_OFS_DIVSEL);

  // control register: reference select and copy enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= sdpp_pkg::SDPP_CTRL_RESET;
    end else if (access_ph && pwrite && (paddr == sdpp_pkg::SDPP_OFS_CTRL)) begin
      ctrl_reg[0] <= pwdata[sdpp_pkg::SDPP_CTRL_REF_SEL_BIT];
      ctrl_reg[1] <= pwdata[sdpp_pkg::SDPP_CTRL_REF_OE_BIT];
    end
  end

  // read view of control and live settings
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      sdpp_pkg::SDPP_OFS_CTRL: begin
        rd_mux[sdpp_pkg::SDPP_CTRL_REF_SEL_BIT] = ctrl_reg[0];
        rd_mux[sdpp_pkg::SDPP_CTRL_REF_OE_BIT]  = ctrl_reg[1];
      end
      sdpp_pkg::SDPP_OFS_FEEDBK: begin
        rd_mux[sdpp_pkg::SDPP_FB_FRAC_LSB +: 12]  = active_reg.feedback_fraction_field;
        rd_mux[sdpp_pkg::SDPP_FB_WHOLE_LSB +: 6]  = active_reg.feedback_whole_field;
      end
      sdpp_pkg::SDPP_OFS_DIVSEL: begin
        rd_mux[sdpp_pkg::SDPP_DS_PRE_LSB +: 3]  = active_reg.pre_divide_select;
        rd_mux[sdpp_pkg::SDPP_DS_NA_LSB +: 3]   = active_reg.out_divide_a_select;
        rd_mux[sdpp_pkg::SDPP_DS_NB_LSB +: 3]   = active_reg.out_divide_b_select;
        rd_mux[sdpp_pkg::SDPP_DS_DIAG_LSB +: 2] = {active_reg.diag_select_hi,
                                                   active_reg.diag_select_lo};
        rd_mux[sdpp_pkg::SDPP_DS_SERIAL_BIT]    = smode_reg;
        rd_mux[sdpp_pkg::SDPP_DS_RATIO_LSB +: 6] = ratio_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // read data captured in setup, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata           = prdata_reg;
  assign pready           = 1'b1;
  assign pslverr          = access_ph & ~mapped;
  assign divider_settings = active_reg;
  assign pre_divide_ratio = ratio_reg;
  assign ref_select       = ctrl_reg[0];
  assign ref_out_enable   = ctrl_reg[1];
  assign serial_mode      = smode_reg;
  assign diag_out         = diag_reg;

endmodule

// ### bench/sdpp_monitor.sv
// Purpose: bound checker of the divider programming port
// Assumes: every assertion runs on pclk, presetn async low
// Notes:   repetition windows cover the two-stage pin synchronisers
`timescale 1ns/10ps
module sdpp_monitor (
  input wire logic                  pclk,                    // bus clock
  input wire logic                  presetn,                 // async reset, low
  input wire logic                  psel,                    // apb select
  input wire logic                  penable,                 // apb enable
  input wire logic                  pwrite,                  // apb direction
  input wire logic [11:0]           paddr,                   // apb address
  input wire logic [31:0]           pwdata,                  // apb write data
  input wire logic                  serial_load_strobe,      // serial load pin
  input wire logic                  parallel_latch_strobe_n, // parallel latch pin
  input wire sdpp_pkg::sdpp_pins_t  par_pins,                // divider pins
  input wire sdpp_pkg::sdpp_frame_t divider_settings,        // active settings
  input wire logic [5:0]            pre_divide_ratio,        // decoded ratio
  input wire logic                  ref_select,              // source select
  input wire logic                  ref_out_enable,          // reference copy on
  input wire logic                  serial_mode,             // serial mode level
  input wire logic                  diag_out                 // diagnostic pin
);
  // ratio per pre-divider code, kept apart from the design's decoder
  localparam logic [5:0] RATIO [8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h10, 6'h19, 6'h20};

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ratio_decode: assert property (
    $stable(divider_settings.pre_divide_select)[*3] |-> pre_divide_ratio == RATIO[divider_settings.pre_divide_select])
    else $error("pre-divide ratio does not match its code");
  a_ref_ctrl_write: assert property (
    psel && penable && pwrite && paddr == 12'h000 |=> {ref_out_enable, ref_select} == $past(pwdata[1:0]))
    else $error("control write not reflected on reference outputs");
  a_ref_oe_cause: assert property (
    $changed(ref_out_enable) |-> $past(psel && penable && pwrite && paddr == 12'h000))
    else $error("reference copy enable moved without a control write");
  a_frac_serial_only: assert property (
    (!serial_load_strobe)[*6] |=> $stable(divider_settings.feedback_fraction_field))
    else $error("fraction changed without a serial load");
  a_pins_pass: assert property (
    (!parallel_latch_strobe_n && $stable(par_pins))[*5] |-> {divider_settings.pre_divide_select,
      divider_settings.feedback_whole_field, divider_settings.out_divide_a_select,
      divider_settings.out_divide_b_select} == par_pins)
    else $error("divider pins not passed through");
  a_latch_hold: assert property (
    (parallel_latch_strobe_n && !serial_load_strobe)[*6] |=> $stable(divider_settings))
    else $error("latched settings moved");
  a_serial_mode: assert property (
    (parallel_latch_strobe_n && !serial_load_strobe)[*4] |-> serial_mode)
    else $error("serial mode missing");
  a_diag_par_low: assert property (
    (!serial_mode)[*3] |-> !diag_out)
    else $error("diagnostic pin high outside serial mode");
  a_diag_code: assert property (
    (divider_settings.diag_select_hi || !divider_settings.diag_select_lo)[*4] |-> !diag_out)
    else $error("diagnostic pin high with a non-routing code");
endmodule

bind sdpp_top sdpp_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .serial_load_strobe(serial_load_strobe),
  .parallel_latch_strobe_n(parallel_latch_strobe_n), .par_pins(par_pins),
  .divider_settings(divider_settings), .pre_divide_ratio(pre_divide_ratio), .ref_select(ref_select),
  .ref_out_enable(ref_out_enable), .serial_mode(serial_mode), .diag_out(diag_out));

// ### bench/sdpp_host_model.sv
// Purpose: serial host that shifts frames into the programming port
// Assumes: 6 ns shift clock, running only inside a frame
// Notes:   the bench owns the parallel latch strobe and the straps
`timescale 1ns/10ps
module sdpp_host_model (
  input  wire logic pclk,               // bus clock, paces the load strobe
  output logic      shift_clk,          // serial clock, idle low
  output logic      serial_data_in,     // serial data line
  output logic      serial_load_strobe  // transfer strobe
);
  initial begin
    shift_clk = 1'b0;
    serial_data_in = 1'b0;
    serial_load_strobe = 1'b0;
  end

  // one bit: data 3 ns before the rise, held 3 ns after; slow adds idle gap
  task automatic shift_bit(input logic b, input logic slow);
    serial_data_in = b;
    #3 shift_clk = 1'b1;
    #3 shift_clk = 1'b0;
    serial_data_in = ~b; // released line must not keep the last bit
    if (slow) #9;
  endtask

  // whole frame, top bit first; the latch strobe stays high meanwhile
  task automatic send_frame(input sdpp_pkg::sdpp_frame_t f, input logic slow);
    for (int i = sdpp_pkg::SDPP_FRAME_BITS - 1; i >= 0; i--) shift_bit(f[i], slow);
  endtask

  // load strobe held n pclk cycles, no shifting while high
  task automatic load_pulse(input int n);
    @(posedge pclk) serial_load_strobe <= 1'b1;
    repeat (n) @(posedge pclk);
    serial_load_strobe <= 1'b0;
  endtask
endmodule

// ### bench/sdpp_top_tb.sv
// Purpose: self-checking bench of the divider programming port
// Assumes: pclk 20 ns, shift clock from the host model
// Notes:   drivers queue expectations, one process compares them
`timescale 1ns/10ps
module sdpp_top_tb;
  localparam logic [5:0] RATIO_TBL [8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h10, 6'h19, 6'h20};
  logic                  pclk = 1'b0, presetn = 1'b0;     // clock and reset
  logic                  psel = 1'b0, penable = 1'b0;     // apb strobes
  logic                  pwrite = 1'b0, pslverr, pready;  // apb control
  logic [11:0]           paddr = 12'h000;                 // apb address
  logic [31:0]           pwdata = 32'h0, prdata, rdv, e;  // apb data, scratch
  logic                  erv, shift_clk, serial_data_in;  // error, serial pins
  logic                  serial_load_strobe, serial_mode; // load pin, mode
  logic                  parallel_latch_strobe_n = 1'b0;  // latch pin
  logic                  ref_select, ref_out_enable, diag_out;
  logic [5:0]            pre_divide_ratio;                // decoded ratio
  sdpp_pkg::sdpp_pins_t  par_pins = '0, strap, p;         // divider pins
  sdpp_pkg::sdpp_frame_t divider_settings, f;             // settings, frame
  logic [31:0]           exp_q [$], got;                  // expectation queue
  event                  got_ev;                          // result appeared
  int                    fails = 0, tests_run = 0;        // counters

  always #10 pclk = ~pclk;

  sdpp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clk(shift_clk), .serial_data_in(serial_data_in), .serial_load_strobe(serial_load_strobe),
    .parallel_latch_strobe_n(parallel_latch_strobe_n), .par_pins(par_pins),
    .divider_settings(divider_settings), .pre_divide_ratio(pre_divide_ratio), .ref_select(ref_select),
    .ref_out_enable(ref_out_enable), .serial_mode(serial_mode), .diag_out(diag_out));
  sdpp_host_model i_host (.pclk(pclk), .shift_clk(shift_clk), .serial_data_in(serial_data_in),
    .serial_load_strobe(serial_load_strobe));

  // ----------------------------------------------------------------
  // comparison and closing
  // ----------------------------------------------------------------
  // oldest note against each reported result
  always @(got_ev) begin
    e = exp_q.pop_front();
    tests_run++;
    if (got !== e) begin
      fails++;
      $display("[FAIL] t=%0t expected=%h got=%h", $time, e, got);
    end
  end
  task automatic check(input logic [31:0] ex, input logic [31:0] g);
    exp_q.push_back(ex);
    got = g;
    ->got_ev;
    #1;
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    results();
  end

  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  // setup, then access until pready; request held until that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      results();
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0, rdv, erv);
    check(ex, rdv);
  endtask
  function automatic logic [31:0] pins_now();
    return {17'h0, divider_settings.pre_divide_select, divider_settings.feedback_whole_field,
            divider_settings.out_divide_a_select, divider_settings.out_divide_b_select};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(35471));
    strap = 15'($urandom);
    @(posedge pclk) par_pins <= strap;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(12'h004, {10'h0, strap.feedback_whole_field, 16'h0});
    rd(12'h008, {2'h0, RATIO_TBL[strap.pre_divide_select], 13'h0, strap.out_divide_b_select, 1'b0,
                 strap.out_divide_a_select, 1'b0, strap.pre_divide_select});
    rd(12'h000, 32'h0);
    $display("test done: power-up defaults");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, i, rdv, erv);
      rd(12'h000, i);
      check(i, {30'h0, ref_out_enable, ref_select});
    end
    apb(1'b0, 12'h0FC, 32'h0, rdv, erv);
    check(32'h1, {31'h0, erv}); // unmapped address must error
    $display("test done: control register");
    // every pre-divider code through the transparent pins
    for (int c = 0; c < 8; c++) begin
      p = 15'($urandom);
      p.pre_divide_select = c[2:0];
      @(posedge pclk) par_pins <= p;
      repeat (5) @(posedge pclk);
      check({17'h0, p}, pins_now());
      check({26'h0, RATIO_TBL[c]}, {26'h0, pre_divide_ratio});
      check(32'h0, {31'h0, diag_out});
    end
    $display("test done: parallel pass-through");
    @(posedge pclk) parallel_latch_strobe_n <= 1'b1;
    repeat (5) @(posedge pclk);
    par_pins <= ~p;
    repeat (6) @(posedge pclk);
    check({17'h0, p}, pins_now());
    $display("test done: parallel latch");
    // each diagnostic code; slow clock on odd codes
    for (int d = 0; d < 4; d++) begin
      f = 29'($urandom);
      {f.diag_select_hi, f.diag_select_lo} = d[1:0];
      if (d == 0) f.feedback_fraction_field = 12'(625 * 4096 / 1000);
      i_host.send_frame(f, d[0]);
      i_host.load_pulse(5);
      repeat (4) @(posedge pclk);
      check({3'h0, f}, {3'h0, divider_settings});
      check(32'h1, {31'h0, serial_mode});
      for (int k = 1; k < 3; k++) begin
        i_host.shift_bit(~f[28 - k], 1'b0);
        repeat (6) @(posedge pclk);
        check((d == 1) ? {31'h0, f[28 - k]} : 32'h0, {31'h0, diag_out});
      end
      check({3'h0, f}, {3'h0, divider_settings});
    end
    $display("test done: serial frames");
    @(posedge pclk) parallel_latch_strobe_n <= 1'b0;
    par_pins <= p;
    repeat (6) @(posedge pclk);
    rd(12'h004, {10'h0, p.feedback_whole_field, 4'h0, f.feedback_fraction_field});
    check(32'h0, {30'h0, serial_mode, diag_out});
    $display("test done: back to parallel");
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(12'h000, 32'h0);
    $display("test done: second reset");
    results();
  end
endmodule
